// ### core/msh_dev.sv
// msh_dev: mote-side end of the low-speed serial link with handshakes.
// assumes all pins are synchronous to mclk and the host side keeps its
// accept line and strobe widths as documented.
`timescale 1ns/1ps
module msh_dev #(
   parameter int unsigned WAIT_CYC  = msh_pkg::WAIT_CYC,
   parameter int unsigned RETRY_CYC = msh_pkg::RETRY_CYC
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   msh_if.dev              bus,
   input  wire logic       link_up,
   input  wire logic       net_joined,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_last,
   output logic            tx_ready,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       rx_ready
);
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_BACKOFF, ST_SEND}
      msh_dstate_t;

   typedef struct packed {
      msh_dstate_t      st;
      msh_pkg::msh_src_t src;
      logic             rts_n;
      logic             ncts_n;
      logic [23:0]      wait_cnt;
      logic [2:0]       idx;
      logic             done;
      logic             boot_pend;
      logic             link_q;
      logic             stamp_pend;
      logic             trig_q;
      logic [31:0]      stamp;
      logic [31:0]      time_cnt;
      logic [9:0]       tx_sh;
      logic [3:0]       tx_bits;
      logic [11:0]      tx_tmr;
      logic             tx_busy;
      logic             tx_rdy;
      logic             rx_act;
      logic [3:0]       rx_bits;
      logic [11:0]      rx_tmr;
      logic [7:0]       rx_sh;
      logic [1:0][7:0]  buf_q;
      logic [1:0]       cnt;
      logic             rx_vld;
   } msh_dev_t;

   msh_dev_t q;
   msh_dev_t next_q;
   logic     push;
   logic [7:0] load_byte;
   logic     load;

   always_comb begin
      next_q    = q;
      push      = 1'b0;
      load      = 1'b0;
      load_byte = 8'h0;
      next_q.time_cnt = q.time_cnt + 32'h1;
      // a falling edge of the trigger while no stamp is pending latches the time at once
      next_q.trig_q = bus.time_trig_n;
      if (q.trig_q && !bus.time_trig_n && !q.stamp_pend) begin
         next_q.stamp_pend = 1'b1;
         next_q.stamp      = q.time_cnt;
      end
      next_q.link_q = link_up;

      unique case (q.st)
         ST_IDLE: begin
            next_q.wait_cnt = 24'h0;
            next_q.idx      = 3'h0;
            next_q.done     = 1'b0;
            if (q.boot_pend) begin
               next_q.boot_pend = 1'b0;
               next_q.src       = msh_pkg::SRC_BOOT;
               next_q.st        = ST_REQ;
               next_q.rts_n     = 1'b0;
            end else if (q.stamp_pend) begin
               next_q.stamp_pend = 1'b0;
               next_q.src        = msh_pkg::SRC_STAMP;
               next_q.st         = ST_REQ;
               next_q.rts_n      = 1'b0;
            end else if (tx_valid) begin
               next_q.src   = msh_pkg::SRC_USER;
               next_q.st    = ST_REQ;
               next_q.rts_n = 1'b0;
            end
         end
         ST_REQ: begin
            if (!bus.host_accept_ready_n) begin
               next_q.rts_n = 1'b1;
               next_q.st    = ST_SEND;
            end else if (q.wait_cnt == 24'(WAIT_CYC - 1)) begin
               next_q.rts_n    = 1'b1;
               next_q.wait_cnt = 24'h0;
               next_q.st       = ST_BACKOFF;
            end else begin
               next_q.wait_cnt = q.wait_cnt + 24'h1;
            end
         end
         ST_BACKOFF: begin
            if (q.wait_cnt == 24'(RETRY_CYC - 1)) begin
               next_q.rts_n    = 1'b0;
               next_q.wait_cnt = 24'h0;
               next_q.st       = ST_REQ;
            end else begin
               next_q.wait_cnt = q.wait_cnt + 24'h1;
            end
         end
         ST_SEND: begin
            if (!q.tx_busy && q.done) begin
               next_q.st = ST_IDLE;
            end else if (!q.tx_busy) begin
               unique case (q.src)
                  msh_pkg::SRC_BOOT: begin
                     load        = 1'b1;
                     load_byte   = msh_pkg::BOOT_TAG;
                     next_q.done = 1'b1;
                  end
                  msh_pkg::SRC_STAMP: begin
                     load        = 1'b1;
                     next_q.idx  = q.idx + 3'h1;
                     next_q.done = q.idx == msh_pkg::STAMP_LAST;
                     // tag first, then the time most significant byte first
                     if (q.idx == 3'h0) begin
                        load_byte = msh_pkg::STAMP_TAG;
                     end else begin
                        load_byte = q.stamp[8 * (4 - q.idx) +: 8];
                     end
                  end
                  default: begin
                     if (q.tx_rdy && tx_valid) begin
                        load          = 1'b1;
                        load_byte     = tx_data;
                        next_q.tx_rdy = 1'b0;
                        next_q.done   = tx_last;
                     end else begin
                        next_q.tx_rdy = 1'b1;
                     end
                  end
               endcase
            end
         end
      endcase

      // after the state case, so a new link rise wins over the clear
      if (link_up && !q.link_q) begin
         next_q.boot_pend = 1'b1;
      end

      if (q.tx_busy) begin
         if (q.tx_tmr == 12'h0) begin
            next_q.tx_tmr  = msh_pkg::BIT_LAST;
            next_q.tx_sh   = {1'b1, q.tx_sh[9:1]};
            next_q.tx_bits = q.tx_bits - 4'h1;
            next_q.tx_busy = q.tx_bits != 4'h1;
         end else begin
            next_q.tx_tmr = q.tx_tmr - 12'h1;
         end
      end else if (load) begin
         next_q.tx_sh   = {1'b1, load_byte, 1'b0};
         next_q.tx_bits = msh_pkg::FRAME_BITS;
         next_q.tx_tmr  = msh_pkg::BIT_LAST;
         next_q.tx_busy = 1'b1;
      end

      // receiver runs in every state, local commands are never gated
      if (!q.rx_act) begin
         if (!bus.rxd) begin
            next_q.rx_act  = 1'b1;
            next_q.rx_bits = 4'h0;
            next_q.rx_tmr  = msh_pkg::HALF_LAST;
         end
      end else if (q.rx_tmr != 12'h0) begin
         next_q.rx_tmr = q.rx_tmr - 12'h1;
      end else begin
         next_q.rx_tmr  = msh_pkg::BIT_LAST;
         next_q.rx_bits = q.rx_bits + 4'h1;
         if (q.rx_bits == 4'h0) begin
            next_q.rx_act = !bus.rxd;
         end else if (q.rx_bits == 4'h9) begin
            next_q.rx_act = 1'b0;
            push          = bus.rxd;
         end else begin
            next_q.rx_sh = {bus.rxd, q.rx_sh[7:1]};
         end
      end

      // two-entry buffer; a byte arriving while full with no read in the same cycle is dropped, which
      // can happen with local commands too, as the host gates only a net packet's first byte on net ready
      if (q.rx_vld && rx_ready) begin
         next_q.buf_q[0] = q.buf_q[1];
         next_q.cnt      = q.cnt - 2'h1;
      end
      if (push && next_q.cnt != 2'h2) begin
         next_q.buf_q[next_q.cnt[0]] = q.rx_sh;
         next_q.cnt                  = next_q.cnt + 2'h1;
      end
      next_q.rx_vld = next_q.cnt != 2'h0;
      // active low: ready only when joined and a slot is free
      next_q.ncts_n = !(net_joined &&
                        next_q.cnt != 2'h2);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q        <= '0;
         q.st     <= ST_IDLE;
         q.src    <= msh_pkg::SRC_USER;
         q.rts_n  <= 1'b1;
         q.ncts_n <= 1'b1;
         q.trig_q <= 1'b1;
         q.link_q <= 1'b0;
         q.tx_sh  <= 10'h3ff;
      end else begin
         q <= next_q;
      end
   end

   assign bus.txd                    = q.tx_sh[0];
   assign bus.dev_send_request_n     = q.rts_n;
   assign bus.dev_net_accept_ready_n = q.ncts_n;
   assign tx_ready                   = q.tx_rdy;
   assign rx_data                    = q.buf_q[0];
   assign rx_valid                   = q.rx_vld;
endmodule : msh_dev

// ### core/msh_host.sv
// msh_host: host-side end of the link: uart, accept line, time strobe.
// assumes the user side honours valid/ready and holds its inputs steady.
`timescale 1ns/1ps
module msh_host (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   msh_if.host             bus,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       tx_first,
   input  wire logic       tx_net,
   output logic            tx_ready,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       can_accept,
   input  wire logic       stamp_req,
   output logic            dev_wants_send,
   output logic            net_ready
);
   typedef struct packed {
      logic        txd;
      logic [9:0]  tx_sh;
      logic [3:0]  tx_bits;
      logic [11:0] tx_tmr;
      logic        tx_busy;
      logic        tx_rdy;
      logic        rx_act;
      logic [3:0]  rx_bits;
      logic [11:0] rx_tmr;
      logic [7:0]  rx_sh;
      logic [7:0]  rx_dat;
      logic        rx_vld;
      logic        acc_n;
      logic        trig_n;
      logic [11:0] trig_cnt;
      logic        wants;
      logic        nready;
   } msh_host_t;

   msh_host_t q;
   msh_host_t next_q;

   always_comb begin
      next_q = q;
      next_q.rx_vld = 1'b0;
      // accept line follows the user's readiness; tie low only if always
      next_q.acc_n  = ~can_accept;
      next_q.wants  = ~bus.dev_send_request_n;
      next_q.nready = ~bus.dev_net_accept_ready_n;
      // a strobe stays low for the full minimum width, retrigger ignored
      if (!q.trig_n) begin
         if (q.trig_cnt == msh_pkg::STB_LAST) begin
            next_q.trig_n = 1'b1;
         end else begin
            next_q.trig_cnt = q.trig_cnt + 12'h1;
         end
      end else if (stamp_req) begin
         next_q.trig_n   = 1'b0;
         next_q.trig_cnt = 12'h0;
      end
      if (q.tx_busy) begin
         if (q.tx_tmr == 12'h0) begin
            next_q.tx_tmr  = msh_pkg::BIT_LAST;
            next_q.tx_sh   = {1'b1, q.tx_sh[9:1]};
            next_q.tx_bits = q.tx_bits - 4'h1;
            next_q.tx_busy = q.tx_bits != 4'h1;
         end else begin
            next_q.tx_tmr = q.tx_tmr - 12'h1;
         end
      end else if (q.tx_rdy && tx_valid &&
                   !(tx_first && tx_net && bus.dev_net_accept_ready_n)) begin
         // ready is a cycle old, so the net gate is looked at again here
         next_q.tx_rdy  = 1'b0;
         next_q.tx_sh   = {1'b1, tx_data, 1'b0};
         next_q.tx_bits = msh_pkg::FRAME_BITS;
         next_q.tx_tmr  = msh_pkg::BIT_LAST;
         next_q.tx_busy = 1'b1;
      end else begin
         // a network packet may only start while the mote is ready
         next_q.tx_rdy = !(tx_valid && tx_first && tx_net &&
                           bus.dev_net_accept_ready_n);
      end
      next_q.txd = next_q.tx_sh[0];
      if (!q.rx_act) begin
         if (!bus.txd) begin
            next_q.rx_act  = 1'b1;
            next_q.rx_bits = 4'h0;
            next_q.rx_tmr  = msh_pkg::HALF_LAST;
         end
      end else if (q.rx_tmr != 12'h0) begin
         next_q.rx_tmr = q.rx_tmr - 12'h1;
      end else begin
         next_q.rx_tmr  = msh_pkg::BIT_LAST;
         next_q.rx_bits = q.rx_bits + 4'h1;
         if (q.rx_bits == 4'h0) begin
            next_q.rx_act = !bus.txd;
         end else if (q.rx_bits == 4'h9) begin
            next_q.rx_act = 1'b0;
            next_q.rx_vld = bus.txd;
            next_q.rx_dat = q.rx_sh;
         end else begin
            next_q.rx_sh = {bus.txd, q.rx_sh[7:1]};
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q         <= '0;
         q.txd     <= 1'b1;
         q.tx_sh   <= 10'h3ff;
         q.acc_n   <= 1'b1;
         q.trig_n  <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign bus.rxd                 = q.txd;
   assign bus.host_accept_ready_n = q.acc_n;
   assign bus.time_trig_n         = q.trig_n;
   assign tx_ready                = q.tx_rdy;
   assign rx_data                 = q.rx_dat;
   assign rx_valid                = q.rx_vld;
   assign dev_wants_send          = q.wants;
   assign net_ready               = q.nready;
endmodule : msh_host

// ### core/msh_if.sv
// msh_if: the pins between the mote end and the host end of the link.
// all handshake lines are active low; the bench joins the two modports.
`timescale 1ns/1ps
interface msh_if;
   logic rxd;
   logic txd;
   logic dev_send_request_n;
   logic dev_net_accept_ready_n;
   logic host_accept_ready_n;
   logic time_trig_n;
   modport dev (
      input  rxd,
      output txd,
      output dev_send_request_n,
      output dev_net_accept_ready_n,
      input  host_accept_ready_n,
      input  time_trig_n
   );
   modport host (
      output rxd,
      input  txd,
      input  dev_send_request_n,
      input  dev_net_accept_ready_n,
      output host_accept_ready_n,
      output time_trig_n
   );
endinterface : msh_if

// ### core/msh_pkg.sv
// msh_pkg: constants and shared types for the mote serial handshake link.
// assumes a single 20 MHz clock on both ends of the link.
package msh_pkg;
   localparam int unsigned CLK_HZ     = 20_000_000;
   localparam int unsigned CLK_MHZ    = CLK_HZ / 1_000_000;
   localparam int unsigned BAUD       = 9600;
   localparam int unsigned BIT_CYC    = CLK_HZ / BAUD;
   localparam int unsigned HALF_CYC   = BIT_CYC / 2;
   localparam int unsigned STROBE_US  = 125;
   localparam int unsigned STROBE_CYC = STROBE_US * CLK_MHZ;
   localparam int unsigned WAIT_US    = 20_000;
   localparam int unsigned RETRY_US   = 5_000;
   localparam int unsigned WAIT_CYC   = WAIT_US * CLK_MHZ;
   localparam int unsigned RETRY_CYC  = RETRY_US * CLK_MHZ;
   localparam logic [11:0] BIT_LAST   = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_LAST  = 12'(HALF_CYC - 1);
   localparam logic [11:0] STB_LAST   = 12'(STROBE_CYC - 1);
   localparam logic [3:0]  FRAME_BITS = 4'ha;
   localparam logic [7:0]  BOOT_TAG   = 8'hb0;
   localparam logic [7:0]  STAMP_TAG  = 8'h71;
   localparam logic [2:0]  STAMP_LAST = 3'h4;
   typedef enum logic [1:0] {SRC_BOOT, SRC_STAMP, SRC_USER} msh_src_t;
endpackage : msh_pkg

// ### testbench/mote_serial_handshake_mode1_tb.sv
// mote_serial_handshake_mode1_tb: drives both link ends from their user sides.
// assumes a 20 MHz clock and short wait and retry counts on the mote end.
`timescale 1ns/1ps
module mote_serial_handshake_mode1_tb;
   localparam int unsigned WAIT_N  = 200;
   localparam int unsigned RETRY_N = 100;
   localparam int          LIMIT   = 30000;
   logic       mclk, reset_n, link_up, net_joined, rx_ready, can_accept;
   logic [7:0] d_tx_data, h_tx_data, d_rx_data, h_rx_data;
   logic       d_tx_valid, d_tx_last, d_tx_ready, d_rx_valid, stamp_req;
   logic       h_tx_valid, h_tx_first, h_tx_net, h_tx_ready, h_rx_valid;
   logic       wants, net_ready;
   int         errors, tests_run;
   msh_if bus ();
   msh_dev #(.WAIT_CYC(WAIT_N), .RETRY_CYC(RETRY_N)) msh_dev_i (
      .mclk(mclk), .reset_n(reset_n), .bus(bus), .link_up(link_up),
      .net_joined(net_joined), .tx_data(d_tx_data), .tx_valid(d_tx_valid),
      .tx_last(d_tx_last), .tx_ready(d_tx_ready), .rx_data(d_rx_data),
      .rx_valid(d_rx_valid), .rx_ready(rx_ready));
   msh_host msh_host_i (
      .mclk(mclk), .reset_n(reset_n), .bus(bus), .tx_data(h_tx_data),
      .tx_valid(h_tx_valid), .tx_first(h_tx_first), .tx_net(h_tx_net),
      .tx_ready(h_tx_ready), .rx_data(h_rx_data), .rx_valid(h_rx_valid),
      .can_accept(can_accept), .stamp_req(stamp_req),
      .dev_wants_send(wants), .net_ready(net_ready));
   msh_assertions #(.WAIT_CYC(WAIT_N), .RETRY_CYC(RETRY_N)) msh_assertions_i (
      .mclk(mclk), .reset_n(reset_n), .rxd(bus.rxd), .txd(bus.txd),
      .dev_send_request_n(bus.dev_send_request_n),
      .dev_net_accept_ready_n(bus.dev_net_accept_ready_n),
      .host_accept_ready_n(bus.host_accept_ready_n),
      .time_trig_n(bus.time_trig_n));
   always #25 mclk = ~mclk;
   task automatic check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict;
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   function automatic logic sig(input int which);
      case (which)
         0: return h_rx_valid;
         1: return h_tx_ready;
         2: return d_tx_ready;
         3: return wants;
         5: return d_rx_valid;
         default: return ~net_ready;
      endcase
   endfunction : sig
   // n returns the number of falling edges waited, counting the one at which the level was seen
   task automatic wait_for(input int which, input logic lvl, output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (sig(which) !== lvl && n < LIMIT);
      if (sig(which) !== lvl) begin
         errors++;
         give_verdict();
      end
   endtask : wait_for
   task automatic h_send(input logic [7:0] d, input logic net);
      int n;
      @(posedge mclk);
      h_tx_data  <= d;
      h_tx_first <= 1'b1;
      h_tx_net   <= net;
      h_tx_valid <= 1'b1;
      wait_for(1, 1'b1, n);
      @(posedge mclk);
      h_tx_valid <= 1'b0;
   endtask : h_send
   task automatic s_boot;
      int n;
      @(posedge mclk);
      link_up <= 1'b1;
      wait_for(0, 1'b1, n);
      check("boot byte", h_rx_data, msh_pkg::BOOT_TAG);
   endtask : s_boot
   task automatic s_retry;
      int n;
      @(posedge mclk);
      can_accept <= 1'b0;
      d_tx_data  <= 8'h5a;
      d_tx_last  <= 1'b1;
      d_tx_valid <= 1'b1;
      wait_for(3, 1'b1, n);
      wait_for(3, 1'b0, n);
      check("request low cycles", n, WAIT_N);
      wait_for(3, 1'b1, n);
      check("retry gap cycles", n, RETRY_N);
      @(posedge mclk);
      can_accept <= 1'b1;
      wait_for(2, 1'b1, n);
      @(posedge mclk);
      d_tx_valid <= 1'b0;
      wait_for(0, 1'b1, n);
      check("user byte", h_rx_data, 8'h5a);
   endtask : s_retry
   task automatic s_stamp;
      int n;
      @(posedge mclk);
      stamp_req <= 1'b1;
      @(posedge mclk);
      stamp_req <= 1'b0;
      wait_for(0, 1'b1, n);
      check("stamp tag", h_rx_data, msh_pkg::STAMP_TAG);
   endtask : s_stamp
   task automatic s_gate;
      int n;
      check("net ready unjoined", net_ready, 1'b0);
      h_send(8'ha5, 1'b0);
      wait_for(5, 1'b1, n);
      @(posedge mclk);
      net_joined <= 1'b1;
      repeat (4) @(negedge mclk);
      check("net ready joined", net_ready, 1'b1);
      h_send(8'h3c, 1'b0);
      wait_for(4, 1'b1, n);
      check("net ready full", net_ready, 1'b0);
      @(posedge mclk);
      h_tx_net   <= 1'b1;
      h_tx_valid <= 1'b1;
      repeat (20) @(negedge mclk);
      check("net packet held", h_tx_ready, 1'b0);
      check("net packet line idle", bus.rxd, 1'b1);
      check("head byte", d_rx_data, 8'ha5);
      @(posedge mclk);
      h_tx_valid <= 1'b0;
      rx_ready   <= 1'b1;
      @(posedge mclk);
      rx_ready   <= 1'b0;
      @(negedge mclk);
      check("second byte", d_rx_data, 8'h3c);
      @(posedge mclk);
      rx_ready   <= 1'b1;
      @(posedge mclk);
      rx_ready   <= 1'b0;
      repeat (4) @(negedge mclk);
      check("buffer drained", d_rx_valid, 1'b0);
      check("net ready again", net_ready, 1'b1);
   endtask : s_gate
   task automatic s_reset;
      @(posedge mclk);
      reset_n    <= 1'b0;
      // a reset drops the network connection as well
      net_joined <= 1'b0;
      @(negedge mclk);
      check("txd in reset", bus.txd, 1'b1);
      check("request in reset", bus.dev_send_request_n, 1'b1);
      check("net line in reset", bus.dev_net_accept_ready_n, 1'b1);
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(negedge mclk);
      check("net line after reset", bus.dev_net_accept_ready_n,
            1'b1);
      @(posedge mclk);
      net_joined <= 1'b1;
      repeat (4) @(negedge mclk);
      check("net line rejoined", bus.dev_net_accept_ready_n,
            1'b0);
   endtask : s_reset
   initial begin
      mclk       = 1'b0;
      reset_n    = 1'b0;
      link_up    = 1'b0;
      net_joined = 1'b0;
      rx_ready   = 1'b0;
      can_accept = 1'b1;
      stamp_req  = 1'b0;
      d_tx_data  = 8'h00;
      d_tx_valid = 1'b0;
      d_tx_last  = 1'b0;
      h_tx_data  = 8'h00;
      h_tx_valid = 1'b0;
      h_tx_first = 1'b0;
      h_tx_net   = 1'b0;
      errors     = 0;
      tests_run  = 0;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      s_boot();
      s_retry();
      // both directions at once: the stamp goes out while the host sends
      fork
         s_stamp();
         s_gate();
      join
      s_reset();
      give_verdict();
   end
endmodule : mote_serial_handshake_mode1_tb

// ### testbench/msh_assertions.sv
// msh_assertions: checks on the pins between the mote end and the host end.
// assumes it sees the link interface signals plus the bench clock and reset.
`timescale 1ns/1ps
module msh_assertions #(
   parameter int unsigned WAIT_CYC  = 200,
   parameter int unsigned RETRY_CYC = 100
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rxd,
   input wire logic txd,
   input wire logic dev_send_request_n,
   input wire logic dev_net_accept_ready_n,
   input wire logic host_accept_ready_n,
   input wire logic time_trig_n
);
   localparam int unsigned LOW_MAX = 9 * msh_pkg::BIT_CYC;
   int unsigned lo_cnt, hi_cnt, tx_lo, rx_lo, trig_lo;
   logic        timed_out, granted;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lo_cnt    <= 0;
         hi_cnt    <= 0;
         tx_lo     <= 0;
         rx_lo     <= 0;
         trig_lo   <= 0;
         timed_out <= 1'b0;
         granted   <= 1'b0;
      end else begin
         lo_cnt  <= dev_send_request_n ? 0 : lo_cnt + 1;
         hi_cnt  <= dev_send_request_n ? hi_cnt + 1 : 0;
         tx_lo   <= txd ? 0 : tx_lo + 1;
         rx_lo   <= rxd ? 0 : rx_lo + 1;
         trig_lo <= time_trig_n ? 0 : trig_lo + 1;
         // a rise after a full wait marks the gap that follows as a retry
         if (dev_send_request_n && lo_cnt != 0)
            timed_out <= (lo_cnt == WAIT_CYC);
         if (!dev_send_request_n && !host_accept_ready_n)
            granted <= 1'b1;
         else if (!dev_send_request_n && hi_cnt != 0)
            granted <= 1'b0;
      end
   end
   sequence s_grant;
      !dev_send_request_n && !host_accept_ready_n;
   endsequence
   sequence s_start;
      $fell(txd);
   endsequence
   a_release_on_grant: assert property (
      s_grant |=> dev_send_request_n)
      else $error("request kept low after accept");
   a_wait_bound: assert property (
      lo_cnt <= WAIT_CYC)
      else $error("request low beyond the wait count");
   a_retry_gap: assert property (
      $fell(dev_send_request_n) && timed_out |-> hi_cnt == RETRY_CYC)
      else $error("retry gap length wrong");
   a_retry_bound: assert property (
      timed_out |-> hi_cnt <= RETRY_CYC)
      else $error("request not raised again after retry gap");
   a_start_granted: assert property (
      s_start |-> granted)
      else $error("byte started without accept");
   a_txd_low_run: assert property (
      tx_lo <= LOW_MAX)
      else $error("txd low longer than a frame");
   a_rxd_low_run: assert property (
      rx_lo <= LOW_MAX)
      else $error("rxd low longer than a frame");
   a_strobe_width: assert property (
      $rose(time_trig_n) |-> trig_lo == msh_pkg::STROBE_CYC)
      else $error("time strobe width wrong");
   a_net_boot_high: assert property (
      $rose(reset_n) |-> dev_net_accept_ready_n)
      else $error("net ready low at reset release");
endmodule : msh_assertions
